// >>> design/eeprom_sel_pkg.sv
package eeprom_sel_pkg;
  // data path widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 15;
  localparam int HI_W = 7;
  localparam int PAGE_W = 6;
  localparam int FIFO_DEPTH = 4;
  // control byte layout; type code value is arbitrary
  localparam logic [3:0] TYPE_CODE = 4'h5;
  localparam int CODE_LSB = 4;
  localparam int SEL_LSB = 1;
  localparam int RW_BIT = 0;
  // bit slots within one ninth-clock frame
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_POS = 4'h8;
  // timing
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int TX_HOLD_NS = 300;
  localparam int TX_HOLD_CYC =
    (TX_HOLD_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int HOLD_W = 4;
  localparam int TWC_MS = 5;
  localparam int TWC_CYC = TWC_MS * (SYS_CLK_HZ / 1000);
  localparam int TWC_W = 17;
  // protocol states
  typedef enum logic [2:0] {
    s_idle, s_ctrl, s_addrh, s_addrl, s_wdata, s_rdata, s_commit
  } state_t;
endpackage

// >>> design/byte_stream_if.sv
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  // producer and consumer views
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> design/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // fill and drain sides
  byte_stream_if.snk i_feed,
  byte_stream_if.src o_drain
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] slot [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;

  // pointer compare; depth must be a power of two
  wire empty = (wr_ptr == rd_ptr);
  wire full = (wr_ptr[PW] != rd_ptr[PW]) &&
              (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  wire push = i_feed.valid & ~full;
  wire pop = o_drain.ready & ~empty;
  assign i_feed.ready = ~full;
  assign o_drain.valid = ~empty;
  assign o_drain.data = slot[rd_ptr[PW-1:0]];

  // storage, one register per entry
  for (genvar e = 0; e < DEPTH; e++) begin : g_slot
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        slot[e] <= '0;
      end else if (push && wr_ptr[PW-1:0] == PW'(e)) begin
        slot[e] <= i_feed.data;
      end
    end
  end

  // pointers advance on accepted transfers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (PW+1)'(push);
      rd_ptr <= rd_ptr + (PW+1)'(pop);
    end
  end
endmodule

// >>> design/eeprom_array.sv
`timescale 1ns/1ps
module eeprom_array #(
  parameter int AW = 15,
  parameter int DW = 8
) (
  // clock
  input wire logic i_clk,
  // write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // registered read port
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] cells [2**AW];

  // one write and one registered read per clock
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      cells[i_waddr] <= i_wdata;
    end
    o_rdata <= cells[i_raddr];
  end
endmodule

// >>> design/serial_eeprom_select_protect.sv
`timescale 1ns/1ps
// Function
// - respond only when all three straps match
// - open strap input reads as zero; here no pull-down, straps are sampled as driven
// - sda changes only while scl low
// - sda edge with scl high: start/stop
// - protect high blocks writes, reads unaffected
// - protect low allows whole array writes
// - write cycle finishes within five milliseconds
// - transmit hold after scl fall, 300 ns
// - sda open-drain, driven low only
// - control byte: code, selects, direction bit
// - no acknowledge during programming cycle
// - protect sampled at stop of write
// - protected write acked, no cycle, ready
module serial_eeprom_select_protect #(
  parameter int TWC_CYCLES = eeprom_sel_pkg::TWC_CYC
) (
  // system clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // two-wire bus, scl also clocks the receiver
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // strap and protect pins
  input wire logic i_chip_select_strap_bit0,
  input wire logic i_chip_select_strap_bit1,
  input wire logic i_chip_select_strap_bit2,
  input wire logic i_write_protect,
  // status
  output logic o_write_busy
);
  localparam int DW = eeprom_sel_pkg::DATA_W;
  localparam int AW = eeprom_sel_pkg::ADDR_W;
  localparam int HW = eeprom_sel_pkg::HI_W;
  localparam int PW = eeprom_sel_pkg::PAGE_W;
  localparam int TW = eeprom_sel_pkg::TWC_W;
  localparam int KW = eeprom_sel_pkg::HOLD_W;
  localparam logic [3:0] ACK_POS = eeprom_sel_pkg::ACK_POS;
  localparam logic [3:0] BIT_LAST = eeprom_sel_pkg::BIT_LAST;
  localparam logic [KW-1:0] HOLD_LOAD =
    KW'(eeprom_sel_pkg::TX_HOLD_CYC);
  localparam logic [KW-1:0] HOLD_ONE = KW'(1);
  localparam logic [TW-1:0] TWC_LOAD = TW'(TWC_CYCLES);
  localparam logic [TW-1:0] TWC_ONE = TW'(1);

  eeprom_sel_pkg::state_t state;
  eeprom_sel_pkg::state_t next_state;

  // ---------------- link side, clocked by scl ----------------
  logic [3:0] lnk_cnt;
  logic [DW-2:0] lnk_sh;
  logic [DW-1:0] lnk_byte;
  logic lnk_tog;
  logic frame_clr;

  // a start clears the bit counter; scl is high then, and the
  // next rising edge is microseconds away
  wire lnk_rst = i_rst | frame_clr;
  wire lnk_done = (lnk_cnt == BIT_LAST);

  // bit counter and shift register, sampled on scl rise
  always_ff @(posedge i_scl or posedge lnk_rst) begin
    if (lnk_rst) begin
      lnk_cnt <= 4'h0;
      lnk_sh <= '0;
    end else begin
      lnk_cnt <= (lnk_cnt == ACK_POS) ? 4'h0 : lnk_cnt + 4'h1;
      if (lnk_cnt != ACK_POS) begin
        lnk_sh <= {lnk_sh[DW-3:0], i_sda};
      end
    end
  end

  // finished byte held stable, announced by a toggle
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      lnk_byte <= '0;
      lnk_tog <= 1'b0;
    end else if (lnk_done) begin
      lnk_byte <= {lnk_sh, i_sda};
      lnk_tog <= ~lnk_tog;
    end
  end

  // ---------------- system side ----------------
  logic [6:0] sync_m;
  logic [6:0] sync_s;
  logic scl_d;
  logic sda_d;
  logic tog_d;

  // two-flop synchronisers: scl, sda, straps, protect, toggle
  // strap pads have no pull-down here; reset alone loads the strap bits as zero
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_m <= 7'h03;
      sync_s <= 7'h03;
    end else begin
      sync_m <= {lnk_tog, i_write_protect,
                 i_chip_select_strap_bit2,
                 i_chip_select_strap_bit1,
                 i_chip_select_strap_bit0, i_sda, i_scl};
      sync_s <= sync_m;
    end
  end

  // previous samples for edge detection
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      tog_d <= 1'b0;
    end else begin
      scl_d <= sync_s[0];
      sda_d <= sync_s[1];
      tog_d <= sync_s[6];
    end
  end

  // bus events
  wire scl_s = sync_s[0];
  wire sda_s = sync_s[1];
  wire [2:0] straps = sync_s[4:2];
  wire wp_s = sync_s[5];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire byte_ev = tog_s_ev();
  function automatic logic tog_s_ev();
    return sync_s[6] ^ tog_d;
  endfunction

  // frame position, counted on scl falls
  logic [3:0] pos;
  logic pos_first;
  logic ack_pend;
  logic drv_low;
  logic [KW-1:0] hold_cnt;
  logic [DW-1:0] tx_byte;
  logic rd_lead;
  logic wr_any;
  logic prot;
  logic [TW-1:0] busy_cnt;
  logic [AW-1:0] ptr;
  logic [AW-1:0] next_ptr;
  logic [DW-1:0] mem_rdata;

  byte_stream_if #(.W(DW)) fifo_in ();
  byte_stream_if #(.W(DW)) fifo_out ();

  // control byte decode
  wire [DW-1:0] rx = lnk_byte;
  wire code_ok =
    (rx[eeprom_sel_pkg::CODE_LSB +: 4] ==
     eeprom_sel_pkg::TYPE_CODE);
  wire sel_ok = (rx[eeprom_sel_pkg::SEL_LSB +: 3] == straps);
  wire rd_req = rx[eeprom_sel_pkg::RW_BIT];
  wire wr_busy = (busy_cnt != '0);
  wire busy_any = (state == eeprom_sel_pkg::s_commit) | wr_busy;
  wire ctrl_hit = code_ok & sel_ok & ~busy_any;

  // state qualifiers
  wire in_ctrl = (state == eeprom_sel_pkg::s_ctrl);
  wire in_addrh = (state == eeprom_sel_pkg::s_addrh);
  wire in_addrl = (state == eeprom_sel_pkg::s_addrl);
  wire in_wdata = (state == eeprom_sel_pkg::s_wdata);
  wire in_rdata = (state == eeprom_sel_pkg::s_rdata);
  wire in_commit = (state == eeprom_sel_pkg::s_commit);

  // master acknowledge slot during reads
  wire rd_ack_slot = in_rdata & scl_rise & (pos == ACK_POS) & ~rd_lead;
  wire rd_nack = rd_ack_slot & sda_s;
  wire rd_next = rd_ack_slot & ~sda_s;

  // acknowledge only bytes that were taken in
  wire ack_set = byte_ev & ((in_ctrl & ctrl_hit) | in_addrh |
                 in_addrl | (in_wdata & fifo_in.ready));

  // data bytes enter the buffer; a full buffer refuses them
  assign fifo_in.valid = byte_ev & in_wdata;
  assign fifo_in.data = rx;
  assign fifo_out.ready = in_commit;
  wire commit_pop = in_commit & fifo_out.valid;
  wire commit_end = in_commit & ~fifo_out.valid;
  wire mem_we = commit_pop & ~prot;

  // pointer: address bytes, page wrap on writes, step on reads
  wire [PW-1:0] page_low = ptr[PW-1:0] + PW'(1);
  assign next_ptr =
    (byte_ev & in_addrh) ? {rx[HW-1:0], ptr[DW-1:0]} :
    (byte_ev & in_addrl) ? {ptr[AW-1:DW], rx} :
    commit_pop ? {ptr[AW-1:PW], page_low} :
    rd_next ? ptr + AW'(1) : ptr;

  // protocol state selection
  always_comb begin
    next_state = state;
    if (in_commit) begin
      if (!fifo_out.valid) begin
        next_state = eeprom_sel_pkg::s_idle;
      end
    end else if (start_det) begin
      next_state = eeprom_sel_pkg::s_ctrl;
    end else if (stop_det) begin
      next_state = wr_any ? eeprom_sel_pkg::s_commit
                          : eeprom_sel_pkg::s_idle;
    end else if (byte_ev) begin
      unique case (state)
        eeprom_sel_pkg::s_ctrl: begin
          if (!ctrl_hit) begin
            next_state = eeprom_sel_pkg::s_idle;
          end else if (rd_req) begin
            next_state = eeprom_sel_pkg::s_rdata;
          end else begin
            next_state = eeprom_sel_pkg::s_addrh;
          end
        end
        eeprom_sel_pkg::s_addrh: next_state = eeprom_sel_pkg::s_addrl;
        eeprom_sel_pkg::s_addrl: next_state = eeprom_sel_pkg::s_wdata;
        eeprom_sel_pkg::s_idle, eeprom_sel_pkg::s_wdata,
        eeprom_sel_pkg::s_rdata, eeprom_sel_pkg::s_commit: begin
          next_state = state;
        end
      endcase
    end else if (rd_nack) begin
      next_state = eeprom_sel_pkg::s_idle;
    end
  end

  // state and address pointer
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= eeprom_sel_pkg::s_idle;
      ptr <= '0;
      frame_clr <= 1'b0;
    end else begin
      state <= next_state;
      ptr <= next_ptr;
      frame_clr <= start_det;
    end
  end

  // frame position: the fall that ends a start opens bit 0
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pos <= 4'h0;
      pos_first <= 1'b0;
    end else if (start_det) begin
      pos <= 4'h0;
      pos_first <= 1'b1;
    end else if (scl_fall) begin
      pos_first <= 1'b0;
      if (!pos_first) begin
        pos <= (pos == ACK_POS) ? 4'h0 : pos + 4'h1;
      end
    end
  end

  // acknowledge request: set wins over the end-of-slot clear
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_pend <= 1'b0;
    end else if (ack_set) begin
      ack_pend <= 1'b1;
    end else if (start_det || (scl_fall && pos == ACK_POS)) begin
      ack_pend <= 1'b0;
    end
  end

  // read byte loaded as the acknowledge slot closes
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_byte <= '0;
      rd_lead <= 1'b0;
    end else begin
      if (scl_fall && pos == ACK_POS && in_rdata) begin
        tx_byte <= mem_rdata;
      end
      if (byte_ev && in_ctrl && ctrl_hit && rd_req) begin
        rd_lead <= 1'b1;
      end else if (scl_rise && pos == ACK_POS) begin
        rd_lead <= 1'b0;
      end
    end
  end

  // what sda should carry once the hold has run out
  wire [2:0] tx_idx = 3'(BIT_LAST - pos);
  wire next_drv = (pos == ACK_POS) ? ack_pend :
                  (in_rdata & ~pos_first & ~tx_byte[tx_idx]);

  // hold-off timer restarted at every scl fall
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_cnt <= '0;
    end else if (scl_fall) begin
      hold_cnt <= HOLD_LOAD;
    end else if (hold_cnt != '0) begin
      hold_cnt <= hold_cnt - HOLD_ONE;
    end
  end

  // sda changes only at hold expiry, well inside scl low
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      drv_low <= 1'b0;
    end else if (start_det || stop_det) begin
      drv_low <= 1'b0;
    end else if (hold_cnt == HOLD_ONE) begin
      drv_low <= next_drv;
    end
  end

  // write bookkeeping and protect sample at stop
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_any <= 1'b0;
      prot <= 1'b0;
    end else begin
      if (fifo_in.valid && fifo_in.ready) begin
        wr_any <= 1'b1;
      end else if (start_det || commit_end) begin
        wr_any <= 1'b0;
      end
      if (stop_det && wr_any && !in_commit) begin
        prot <= wp_s;
      end
    end
  end

  // self-timed write cycle, skipped when protected
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_cnt <= '0;
    end else if (commit_end && !prot) begin
      busy_cnt <= TWC_LOAD;
    end else if (busy_cnt != '0) begin
      busy_cnt <= busy_cnt - TWC_ONE;
    end
  end

  // incoming data buffer
  byte_fifo #(
    .W(DW),
    .DEPTH(eeprom_sel_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_feed(fifo_in),
    .o_drain(fifo_out)
  );

  // storage array
  eeprom_array #(
    .AW(AW),
    .DW(DW)
  ) u_array (
    .i_clk(i_sys_clk),
    .i_we(mem_we),
    .i_waddr(ptr),
    .i_wdata(fifo_out.data),
    .i_raddr(ptr),
    .o_rdata(mem_rdata)
  );

  // open-drain pin: only ever pulls low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = drv_low;
  assign o_write_busy = wr_busy;
endmodule

// >>> tb/eeprom_sel_properties.sv
`timescale 1ns/1ps
module eeprom_sel_properties #(
  parameter int TWC_CYCLES = 125000
) (
  // system clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // two-wire bus
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  // strap and protect pins
  input wire logic i_chip_select_strap_bit0,
  input wire logic i_chip_select_strap_bit1,
  input wire logic i_chip_select_strap_bit2,
  input wire logic i_write_protect,
  // status
  input wire logic o_write_busy
);
  logic scl_q, sda_q, first, muted, wp_stop;
  logic [3:0] bits;
  logic [7:0] sh;
  logic [17:0] cnt;
  // bus events as seen at the system clock
  wire start_ev = scl_q && i_scl && sda_q && !i_sda;
  wire stop_ev = scl_q && i_scl && !sda_q && i_sda;
  wire rise_ev = !scl_q && i_scl;
  wire [6:0] want = {eeprom_sel_pkg::TYPE_CODE, i_chip_select_strap_bit2,
    i_chip_select_strap_bit1, i_chip_select_strap_bit0};
  // frame tracker, protect at stop and busy length counter
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first <= 1'b0;
      muted <= 1'b0;
      wp_stop <= 1'b0;
      bits <= 4'h0;
      sh <= 8'h00;
      cnt <= 18'h0;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      cnt <= o_write_busy ? cnt + 18'h1 : 18'h0;
      if (stop_ev) wp_stop <= i_write_protect;
      if (start_ev) begin
        bits <= 4'h0;
        first <= 1'b1;
        muted <= 1'b0;
      end else if (rise_ev) begin
        sh <= {sh[6:0], i_sda};
        bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
        if (bits == 4'h8) first <= 1'b0;
        if (first && bits == 4'h7 && sh[6:0] != want) muted <= 1'b1;
      end
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_drive_low_only: assert property (!o_sda_out)
    else $error("sda output value not low");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("sda drive changed while scl high");
  a_hold_after_fall: assert property (
    $fell(i_scl) |=> $stable(o_sda_oe) [*8])
    else $error("sda drive changed too soon after scl fall");
  a_busy_no_ack: assert property (o_write_busy |-> !o_sda_oe)
    else $error("sda driven during write cycle");
  a_busy_length: assert property (
    $fell(o_write_busy) |-> cnt == 18'(TWC_CYCLES))
    else $error("write cycle length wrong");
  a_ctrl_match: assert property (
    $rose(o_sda_oe) && first |-> bits == 4'h8 && sh[7:1] == want)
    else $error("control byte acked without match");
  a_mute_release: assert property (muted |-> !o_sda_oe)
    else $error("sda driven after address mismatch");
  a_protect_no_cycle: assert property (
    $rose(o_write_busy) |-> !wp_stop)
    else $error("write cycle started while protected");
  c_busy: cover property ($rose(o_write_busy));
  c_ack: cover property ($rose(o_sda_oe) && first);
  c_muted: cover property ($rose(muted));
endmodule

bind serial_eeprom_select_protect eeprom_sel_properties #(
  .TWC_CYCLES(TWC_CYCLES)
) u_props (
  .i_sys_clk(i_sys_clk),
  .i_rst(i_rst),
  .i_scl(i_scl),
  .i_sda(i_sda),
  .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe),
  .i_chip_select_strap_bit0(i_chip_select_strap_bit0),
  .i_chip_select_strap_bit1(i_chip_select_strap_bit1),
  .i_chip_select_strap_bit2(i_chip_select_strap_bit2),
  .i_write_protect(i_write_protect),
  .o_write_busy(o_write_busy)
);

// >>> tb/two_wire_master_model.sv
`timescale 1ns/1ps
module two_wire_master_model (
  // link clock
  input wire logic i_link_clk,
  // bus lines
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  localparam int LOW_T = 48;
  localparam int HIGH_T = 24;
  // bus idle: both lines released
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_link_clk);
  endtask
  // data changes only while scl is low
  task automatic bit_io(input logic b, output logic got);
    tick(LOW_T / 4);
    o_sda_oe <= !b;
    tick(LOW_T * 3 / 4);
    o_scl <= 1'b1;
    tick(HIGH_T / 2);
    got = i_sda;
    tick(HIGH_T / 2);
    o_scl <= 1'b0;
  endtask
  // start: sda falls while scl is high
  task automatic start();
    o_sda_oe <= 1'b0;
    tick(LOW_T / 2);
    o_scl <= 1'b1;
    tick(HIGH_T);
    o_sda_oe <= 1'b1;
    tick(HIGH_T);
    o_scl <= 1'b0;
  endtask
  // stop: sda rises while scl is high, then the clock stands
  task automatic stop();
    tick(LOW_T / 4);
    o_sda_oe <= 1'b1;
    tick(LOW_T * 3 / 4);
    o_scl <= 1'b1;
    tick(HIGH_T);
    o_sda_oe <= 1'b0;
    tick(LOW_T);
  endtask
  // one byte out, msb first, then the answer slot
  task automatic wbyte(input logic [7:0] v, output logic nack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(v[i], g);
    bit_io(1'b1, nack);
  endtask
  // one byte in; the answer slot acks unless it is the last
  task automatic rbyte(input logic last, output logic [7:0] v);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, g);
  endtask
endmodule

// >>> tb/serial_eeprom_select_protect_test.sv
`timescale 1ns/1ps
module serial_eeprom_select_protect_test;
  localparam int TWC = 2000;
  logic i_sys_clk, link_clk, i_rst, wp, ack;
  logic [2:0] strap;
  logic [7:0] d;
  logic [14:0] a;
  logic [7:0] mem [int];
  int failures, checks_done, seed;
  realtime t_rise, t_fall;
  wire scl, m_oe, d_oe, d_out, busy;
  // open-drain bus with pull-up
  wire sda = !m_oe && (!d_oe || d_out);
  serial_eeprom_select_protect #(
    .TWC_CYCLES(TWC)
  ) u_serial_eeprom_select_protect (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_scl(scl),
    .i_sda(sda),
    .o_sda_out(d_out),
    .o_sda_oe(d_oe),
    .i_chip_select_strap_bit0(strap[0]),
    .i_chip_select_strap_bit1(strap[1]),
    .i_chip_select_strap_bit2(strap[2]),
    .i_write_protect(wp),
    .o_write_busy(busy)
  );
  two_wire_master_model u_two_wire_master_model (
    .i_link_clk(link_clk),
    .i_sda(sda),
    .o_scl(scl),
    .o_sda_oe(m_oe)
  );
  // system clock and unrelated link clock
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // write cycle edges
  always @(posedge busy) t_rise = $realtime;
  always @(negedge busy) t_fall = $realtime;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // control byte: type code, selects, direction
  function automatic logic [7:0] ctrl(input logic [2:0] s, input logic r);
    return {eeprom_sel_pkg::TYPE_CODE, s, r};
  endfunction
  // short forms of the master's bus actions
  task automatic go();
    u_two_wire_master_model.start();
  endtask
  task automatic halt();
    u_two_wire_master_model.stop();
  endtask
  task automatic send(input logic [7:0] v);
    u_two_wire_master_model.wbyte(v, ack);
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 3000) begin
      @(negedge i_sys_clk);
      n++;
    end
  endtask
  // start, write control byte and both address bytes
  task automatic head(input logic [14:0] ad);
    go();
    send(ctrl(strap, 1'b0));
    check(32'(ack), 0);
    send({1'b0, ad[14:8]});
    check(32'(ack), 0);
    send(ad[7:0]);
    check(32'(ack), 0);
  endtask
  task automatic wr(input logic [14:0] ad, input int n, input logic p);
    logic [14:0] k;
    @(negedge i_sys_clk);
    wp = p;
    head(ad);
    for (int i = 0; i < n; i++) begin
      k = ad + 15'(i);
      d = 8'($random(seed));
      send(d);
      check(32'(ack), 32'(i > 3));
      if (i < 4 && !p) mem[k] = d;
    end
    halt();
  endtask
  task automatic rd(input logic [14:0] ad, input int n);
    logic [14:0] k;
    head(ad);
    go();
    send(ctrl(strap, 1'b1));
    check(32'(ack), 0);
    for (int i = 0; i < n; i++) begin
      k = ad + 15'(i);
      u_two_wire_master_model.rbyte(i == n - 1, d);
      check(32'(d), 32'(mem[k]));
    end
    halt();
  endtask
  // reset, then the scenarios in turn
  initial begin
    failures = 0;
    checks_done = 0;
    seed = 32'h2986;
    i_rst = 1'b1;
    wp = 1'b0;
    strap = 3'($random(seed));
    repeat (8) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    // every select code; a refused device stays deaf until start
    for (int s = 0; s < 8; s++) begin
      go();
      send(ctrl(3'(s), 1'b0));
      check(32'(ack), 32'(3'(s) != strap));
      if (3'(s) != strap) begin
        send(ctrl(strap, 1'b0));
        check(32'(ack), 1);
      end
      halt();
    end
    go();
    send({~eeprom_sel_pkg::TYPE_CODE, strap, 1'b0});
    check(32'(ack), 1);
    halt();
    // top address, refusal while busy, cycle length
    wr(15'h7FFF, 1, 1'b0);
    wait_busy(1'b1);
    check(32'(busy), 1);
    go();
    send(ctrl(strap, 1'b0));
    check(32'(ack), 1);
    halt();
    wait_busy(1'b0);
    check(32'(int'((t_fall - t_rise) / 40.0)), TWC);
    rd(15'h7FFF, 1);
    // four bytes, the fifth refused when the buffer is full
    a = 15'($random(seed));
    a[5:0] = 6'h08;
    wr(a, 5, 1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(a, 4);
    // protected write: acked, no cycle, next command at once
    wr(a, 2, 1'b1);
    check(32'(busy), 0);
    rd(a, 2);
    // protect raised after stop leaves the cycle running
    wr(a + 15'h10, 1, 1'b0);
    @(negedge i_sys_clk);
    wp = 1'b1;
    wait_busy(1'b1);
    check(32'(busy), 1);
    wait_busy(1'b0);
    rd(a + 15'h10, 1);
    // protect dropped before stop: the level at stop decides
    @(negedge i_sys_clk);
    wp = 1'b1;
    head(a + 15'h20);
    d = 8'($random(seed));
    send(d);
    check(32'(ack), 0);
    mem[a + 15'h20] = d;
    @(negedge i_sys_clk);
    wp = 1'b0;
    halt();
    wait_busy(1'b1);
    check(32'(busy), 1);
    wait_busy(1'b0);
    rd(a + 15'h20, 1);
    test_done();
  end
  // cut a hang short
  initial begin
    #3_000_000;
    failures++;
    test_done();
  end
endmodule
